// file: hw/shunt_pwm_defines.vh
// Purpose: shared constants for the single-shunt pwm and sampling block
// Assumes: 100 MHz timer clock
// Notes: counts derived from times by expression
`ifndef SHUNT_PWM_DEFINES_VH
`define SHUNT_PWM_DEFINES_VH

`define CLK_MHZ 100
`define CNT_W 13
`define CUR_W 16
`define ADC_W 12
// carrier half period in counts: 100 us period at 100 MHz -> 5000 counts up/down
`define CTRL_PERIOD_US 100
`define SLOW_PERIOD_US 500
`define HALF_PERIOD (`CTRL_PERIOD_US * `CLK_MHZ / 2)
`define SLOW_RATIO (`SLOW_PERIOD_US / `CTRL_PERIOD_US)
`define DEAD_DEFAULT 13'h0064
`define WINDOW_DEFAULT 13'h00C8
`define ADC_ZERO_CODE 12'h745
`define ADC_TOP_CODE 12'h0E8B
`define ADC_BOTTOM_CODE 12'h000

`endif

// file: hw/dead_time_gen.v
// Purpose: complementary arm drive with dead time for one phase
// Assumes: reference level from carrier compare, synchronous to clock
// Notes: both arms held off for dead_cnt + 1 cycles at every transition
`timescale 1ns/1ps
`default_nettype none
`include "shunt_pwm_defines.vh"

module dead_time_gen (
	// clock and reset
	input wire ref_clk_i,
	input wire resetn_i,
	// control
	input wire ref_i,
	input wire [`CNT_W-1:0] dead_cnt_i,
	// arm drive
	output reg upper_o,
	output reg lower_o
);

reg last_ref;
reg [`CNT_W-1:0] dead;

// ****************************************
// dead time insertion
// ****************************************
// an edge of the reference kills both arms, the new arm turns on after the gap
always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		last_ref <= 1'b0;
		dead <= {`CNT_W{1'b0}};
		upper_o <= 1'b0;
		lower_o <= 1'b0;
	end else begin
		last_ref <= ref_i;
		if (ref_i != last_ref) begin
			dead <= dead_cnt_i;
			upper_o <= 1'b0;
			lower_o <= 1'b0;
		end else if (dead != {`CNT_W{1'b0}}) begin
			dead <= dead - 1'b1;
		end else begin
			upper_o <= ref_i;
			lower_o <= ~ref_i;
		end
	end
end

endmodule
`default_nettype wire

// file: hw/sample_store.v
// Purpose: registered store of the two shunt samples
// Assumes: one write strobe per sample point
// Notes: read data come out of registers
`timescale 1ns/1ps
`default_nettype none
`include "shunt_pwm_defines.vh"

module sample_store (
	// clock and reset
	input wire ref_clk_i,
	input wire resetn_i,
	// write side
	input wire wr_i,
	input wire wr_sel_i,
	input wire [`ADC_W-1:0] wr_data_i,
	// read side
	output reg [`ADC_W-1:0] a_data_o,
	output reg [`ADC_W-1:0] b_data_o
);

// ****************************************
// storage
// ****************************************
// slot 0 holds point A, slot 1 point B
always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		a_data_o <= `ADC_ZERO_CODE;
		b_data_o <= `ADC_ZERO_CODE;
	end else if (wr_i) begin
		if (wr_sel_i)
			b_data_o <= wr_data_i;
		else
			a_data_o <= wr_data_i;
	end
end

endmodule
`default_nettype wire

// file: hw/single_shunt_pwm_adc_sampler.v
// Purpose: three-phase centre-aligned pwm with single-shunt sample scheduling
// Assumes: duties in carrier counts, 0 .. half period; adc answers with done pulse
// Notes: phase index 0 = u, 1 = v, 2 = w
`timescale 1ns/1ps
`default_nettype none
`include "shunt_pwm_defines.vh"

module single_shunt_pwm_adc_sampler (
	// clock and reset
	input wire ref_clk_i,
	input wire resetn_i,
	// duty input from control software
	input wire [`CNT_W-1:0] duty_u_i,
	input wire [`CNT_W-1:0] duty_v_i,
	input wire [`CNT_W-1:0] duty_w_i,
	input wire duty_load_i,
	input wire [`CNT_W-1:0] dead_cnt_i,
	input wire [`CNT_W-1:0] min_window_i,
	// protection
	input wire estop_i,
	// adc interface
	input wire adc_done_i,
	input wire [`ADC_W-1:0] adc_data_i,
	output wire adc_start_a_o,
	output wire adc_start_b_o,
	// gate drive, enable low while driving
	output wire [2:0] gate_upper_o,
	output wire [2:0] gate_lower_o,
	output wire gate_oe_n_o,
	// reconstructed currents, signed, and events
	output reg signed [`CUR_W-1:0] cur_u_o,
	output reg signed [`CUR_W-1:0] cur_v_o,
	output reg signed [`CUR_W-1:0] cur_w_o,
	output reg cur_valid_o,
	output reg ctrl_event_o,
	output reg slow_event_o,
	output reg clamp_o
);

// counts are worked out as integers first, then cut to the register width on purpose
localparam integer HALF_INT = `HALF_PERIOD;
localparam integer SLOW_INT = `SLOW_RATIO - 1;
localparam [`CNT_W-1:0] HALF = HALF_INT[`CNT_W-1:0];
localparam [2:0] SLOW_N = SLOW_INT[2:0];

// carrier state, one-hot
localparam [1:0] ST_UP = 2'b01;
localparam [1:0] ST_DOWN = 2'b10;

reg [1:0] state;
reg [`CNT_W-1:0] carrier_counter;
reg [2:0] slow_cnt;
// up-count and down-count compares, they differ only for a shifted phase
reg [`CNT_W-1:0] cmp_up [0:2];
reg [`CNT_W-1:0] cmp_dn [0:2];
reg [1:0] hi_idx;
reg [1:0] lo_idx;
reg [`CNT_W-1:0] adc_trigger_compare_a;
reg [`CNT_W-1:0] adc_trigger_compare_b;
reg pend_sel;
reg estop_hold;
reg [2:0] ref_lvl;
// one loop index per process so that no variable has two drivers
integer k;
integer kr;
integer kc;

// ****************************************
// ordering and edge shifting
// ****************************************
reg [`CNT_W-1:0] d0, d1, d2;
reg [1:0] i_hi, i_mid, i_lo;
reg [`CNT_W-1:0] dh, dm, dl, nm, nl;
reg [`CNT_W:0] sum_chk;
reg next_clamp;
reg [`CNT_W-1:0] next_up [0:2];
reg [`CNT_W-1:0] next_dn [0:2];
reg [`CNT_W-1:0] dn_m, dn_l;
reg [`CNT_W+1:0] span_m, span_l;
always @* begin
	d0 = duty_u_i;
	d1 = duty_v_i;
	d2 = duty_w_i;
	// sort the three duties (ties go to lower index)
	if (d0 >= d1 && d0 >= d2) begin
		i_hi = 2'd0;
		if (d1 >= d2) begin i_mid = 2'd1; i_lo = 2'd2; end
		else begin i_mid = 2'd2; i_lo = 2'd1; end
	end else if (d1 >= d2) begin
		i_hi = 2'd1;
		if (d0 >= d2) begin i_mid = 2'd0; i_lo = 2'd2; end
		else begin i_mid = 2'd2; i_lo = 2'd0; end
	end else begin
		i_hi = 2'd2;
		if (d0 >= d1) begin i_mid = 2'd0; i_lo = 2'd1; end
		else begin i_mid = 2'd1; i_lo = 2'd0; end
	end
	dh = (i_hi == 2'd0) ? d0 : (i_hi == 2'd1) ? d1 : d2;
	dm = (i_mid == 2'd0) ? d0 : (i_mid == 2'd1) ? d1 : d2;
	dl = (i_lo == 2'd0) ? d0 : (i_lo == 2'd1) ? d1 : d2;
	// compare value: phase upper on while counter >= HALF - duty
	// a smaller duty switches later in the up-count, so push it later only
	next_clamp = 1'b0;
	nm = dm;
	if (dh - dm < min_window_i) begin
		if (dh > min_window_i) begin
			nm = dh - min_window_i;
		end else begin
			nm = {`CNT_W{1'b0}}; // no room left before the peak
			next_clamp = 1'b1;
		end
	end
	nl = dl;
	sum_chk = {1'b0, nm} - {1'b0, min_window_i};
	// compared one bit wider: the lowest duty may already exceed the shifted middle one
	if ({1'b0, nm} < {1'b0, dl} + {1'b0, min_window_i}) begin
		if (sum_chk[`CNT_W]) begin
			nl = {`CNT_W{1'b0}}; // edge lands on carrier end
			next_clamp = 1'b1;
		end else begin
			nl = sum_chk[`CNT_W-1:0];
		end
	end
	// the down-count half gives back what the late up-count edge took, so the duty stays
	span_m = {1'b0, dm, 1'b0} - {2'b00, nm};
	span_l = {1'b0, dl, 1'b0} - {2'b00, nl};
	if (span_m > {2'b00, HALF}) begin
		dn_m = {`CNT_W{1'b0}}; // give-back edge held at the valley
		next_clamp = 1'b1;
	end else begin
		dn_m = HALF - span_m[`CNT_W-1:0];
	end
	if (span_l > {2'b00, HALF}) begin
		dn_l = {`CNT_W{1'b0}}; // give-back edge held at the valley
		next_clamp = 1'b1;
	end else begin
		dn_l = HALF - span_l[`CNT_W-1:0];
	end
	for (k = 0; k < 3; k = k + 1) begin
		next_up[k] = HALF;
		next_dn[k] = HALF;
	end
	next_up[i_hi] = HALF - dh;
	next_dn[i_hi] = HALF - dh;
	next_up[i_mid] = HALF - nm;
	next_dn[i_mid] = dn_m;
	next_up[i_lo] = HALF - nl;
	next_dn[i_lo] = dn_l;
end

// ****************************************
// carrier counter and events
// ****************************************
// compares and ordering only reload at the valley so a period is never torn
always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		state <= ST_UP;
		carrier_counter <= {`CNT_W{1'b0}};
		slow_cnt <= 3'h0;
		ctrl_event_o <= 1'b0;
		slow_event_o <= 1'b0;
		clamp_o <= 1'b0;
		hi_idx <= 2'd0;
		lo_idx <= 2'd0;
		adc_trigger_compare_a <= HALF;
		adc_trigger_compare_b <= HALF;
		for (kc = 0; kc < 3; kc = kc + 1) begin
			cmp_up[kc] <= HALF;
			cmp_dn[kc] <= HALF;
		end
	end else begin
		ctrl_event_o <= 1'b0;
		slow_event_o <= 1'b0;
		case (state)
		ST_UP: begin
			if (carrier_counter == HALF - 1'b1)
				state <= ST_DOWN;
			carrier_counter <= carrier_counter + 1'b1;
		end
		ST_DOWN: begin
			if (carrier_counter == {{(`CNT_W-1){1'b0}}, 1'b1})
				state <= ST_UP;
			carrier_counter <= carrier_counter - 1'b1;
		end
		default: state <= ST_UP;
		endcase
		if (state == ST_DOWN && carrier_counter == {{(`CNT_W-1){1'b0}}, 1'b1}) begin
			ctrl_event_o <= 1'b1;
			slow_cnt <= (slow_cnt == SLOW_N) ? 3'h0 : slow_cnt + 1'b1;
			slow_event_o <= (slow_cnt == SLOW_N);
			if (duty_load_i) begin
				for (kc = 0; kc < 3; kc = kc + 1) begin
					cmp_up[kc] <= next_up[kc];
					cmp_dn[kc] <= next_dn[kc];
				end
				hi_idx <= i_hi;
				lo_idx <= i_lo;
				clamp_o <= next_clamp;
				// A: between highest and middle edges, B: between middle and lowest
				adc_trigger_compare_a <= HALF - dh + {1'b0, dead_cnt_i[`CNT_W-1:1]};
				adc_trigger_compare_b <= HALF - nm + {1'b0, dead_cnt_i[`CNT_W-1:1]};
			end
		end
	end
end

// ****************************************
// pwm reference and arms
// ****************************************
// up half: on from the compare to the peak; down half: on while above its compare
// a compare at the half count keeps the phase off in both halves
always @* begin
	for (kr = 0; kr < 3; kr = kr + 1) begin
		if (state == ST_UP)
			ref_lvl[kr] = (carrier_counter >= cmp_up[kr]);
		else
			ref_lvl[kr] = (carrier_counter > cmp_dn[kr]);
	end
end

genvar g;
generate
	for (g = 0; g < 3; g = g + 1) begin : g_arm
		dead_time_gen u_dead (
			.ref_clk_i(ref_clk_i),
			.resetn_i(resetn_i),
			.ref_i(ref_lvl[g]),
			.dead_cnt_i(dead_cnt_i),
			.upper_o(gate_upper_o[g]),
			.lower_o(gate_lower_o[g])
		);
	end
endgenerate

// outputs float at once on stop, held until reset
always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i)
		estop_hold <= 1'b0;
	else if (estop_i)
		estop_hold <= 1'b1;
end
assign gate_oe_n_o = estop_i | estop_hold;

// ****************************************
// adc triggers and sample routing
// ****************************************
// triggers only on the up-count so each sample pair is taken once per period
assign adc_start_a_o = (state == ST_UP) && (carrier_counter == adc_trigger_compare_a);
assign adc_start_b_o = (state == ST_UP) && (carrier_counter == adc_trigger_compare_b);

always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i)
		pend_sel <= 1'b0;
	else if (adc_start_a_o)
		pend_sel <= 1'b0;
	else if (adc_start_b_o)
		pend_sel <= 1'b1;
end

wire [`ADC_W-1:0] samp_a;
wire [`ADC_W-1:0] samp_b;
reg b_done;
sample_store u_store (
	.ref_clk_i(ref_clk_i),
	.resetn_i(resetn_i),
	.wr_i(adc_done_i),
	.wr_sel_i(pend_sel),
	.wr_data_i(adc_data_i),
	.a_data_o(samp_a),
	.b_data_o(samp_b)
);

// ****************************************
// current reconstruction
// ****************************************
// linear offset from mid code, signed result in adc lsb
wire signed [`CUR_W-1:0] ia = $signed({4'h0, samp_a}) - $signed({4'h0, `ADC_ZERO_CODE});
wire signed [`CUR_W-1:0] ib = $signed({4'h0, `ADC_ZERO_CODE}) - $signed({4'h0, samp_b});
wire signed [`CUR_W-1:0] ic = -(ia + ib);

always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		b_done <= 1'b0;
		cur_valid_o <= 1'b0;
		cur_u_o <= {`CUR_W{1'b0}};
		cur_v_o <= {`CUR_W{1'b0}};
		cur_w_o <= {`CUR_W{1'b0}};
	end else begin
		b_done <= adc_done_i & pend_sel;
		cur_valid_o <= b_done;
		if (b_done) begin
			// highest gets A, lowest gets negated B, the other the negated sum of both
			cur_u_o <= (hi_idx == 2'd0) ? ia : (lo_idx == 2'd0) ? ib : ic;
			cur_v_o <= (hi_idx == 2'd1) ? ia : (lo_idx == 2'd1) ? ib : ic;
			cur_w_o <= (hi_idx == 2'd2) ? ia : (lo_idx == 2'd2) ? ib : ic;
		end
	end
end

endmodule
`default_nettype wire

// file: dv/shunt_checker.sv
// Purpose: port checks for the single-shunt pwm block
// Assumes: one clock, asynchronous active-low reset
// Notes: attached by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
`include "shunt_pwm_defines.vh"
module shunt_checker (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// watched ports
	input wire logic estop_i,
	input wire logic adc_done_i,
	input wire logic adc_start_a_o,
	input wire logic adc_start_b_o,
	input wire logic [2:0] gate_upper_o,
	input wire logic [2:0] gate_lower_o,
	input wire logic gate_oe_n_o,
	input wire logic signed [`CUR_W-1:0] cur_u_o,
	input wire logic signed [`CUR_W-1:0] cur_v_o,
	input wire logic signed [`CUR_W-1:0] cur_w_o,
	input wire logic cur_valid_o,
	input wire logic ctrl_event_o,
	input wire logic slow_event_o
);
	logic [13:0] gap;
	logic [2:0] nctl;
	logic seen;
	logic sseen;
	// event spacing counters; the first event has no reference so it is skipped
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			gap <= 14'h0000;
			nctl <= 3'h0;
			seen <= 1'b0;
			sseen <= 1'b0;
		end else begin
			gap <= ctrl_event_o ? 14'h0000 : gap + 14'h0001;
			seen <= seen | ctrl_event_o;
			sseen <= sseen | slow_event_o;
			nctl <= slow_event_o ? 3'h0 : nctl + {2'h0, ctrl_event_o};
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	chk_estop_float: assert property (estop_i |-> gate_oe_n_o)
		else $error("gates not floated on stop");
	chk_no_overlap: assert property ((gate_upper_o & gate_lower_o) == 3'h0)
		else $error("both arms on");
	chk_dead_lower: assert property ($rose(gate_lower_o[0]) |-> !$past(gate_upper_o[0], 2))
		else $error("no dead time before lower arm");
	chk_dead_upper: assert property ($rose(gate_upper_o[1]) |-> !$past(gate_lower_o[1], 2))
		else $error("no dead time before upper arm");
	chk_ctrl_period: assert property (ctrl_event_o && seen |-> gap == 14'h270F)
		else $error("control event period wrong");
	chk_slow_ratio: assert property (slow_event_o && sseen |-> ctrl_event_o && nctl == 3'h4)
		else $error("slow event ratio wrong");
	chk_sum_zero: assert property (cur_valid_o |-> cur_u_o + cur_v_o + cur_w_o == 16'sh0000)
		else $error("currents do not sum to zero");
	chk_valid_after: assert property (cur_valid_o |-> $past(adc_done_i, 2))
		else $error("valid not two cycles after done");
	chk_start_pulse: assert property (adc_start_a_o |-> !adc_start_b_o ##1 !adc_start_a_o)
		else $error("start pulse malformed");
	chk_estop_held: assert property (gate_oe_n_o |=> gate_oe_n_o)
		else $error("gates driven again after stop");
	chk_cur_hold: assert property (!cur_valid_o |-> $stable(cur_u_o) && $stable(cur_v_o) && $stable(cur_w_o))
		else $error("currents changed without valid");
endmodule
bind single_shunt_pwm_adc_sampler shunt_checker shunt_checker_i (.ref_clk_i, .resetn_i, .estop_i,
	.adc_done_i, .adc_start_a_o, .adc_start_b_o, .gate_upper_o, .gate_lower_o, .gate_oe_n_o,
	.cur_u_o, .cur_v_o, .cur_w_o, .cur_valid_o, .ctrl_event_o, .slow_event_o);
`default_nettype wire

// file: dv/adc_model.sv
// Purpose: converter answering start pulses with a done pulse
// Assumes: one conversion at a time, latency set by the bench
// Notes: data line shows the inverse of the last code when idle
`timescale 1ns/1ps
`default_nettype none
module adc_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// requests and codes
	input wire logic start_a_i,
	input wire logic start_b_i,
	input wire logic [11:0] code_a_i,
	input wire logic [11:0] code_b_i,
	input wire logic [7:0] lat_i,
	// answer
	output logic done_o,
	output logic [11:0] data_o
);
	logic busy;
	logic [7:0] cnt;
	logic [11:0] code;
	logic [11:0] last;
	// idle data shows the inverse of the last code so a stale sample is never read as valid
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy <= 1'b0;
			done_o <= 1'b0;
			last <= 12'h000;
			data_o <= 12'hFFF;
		end else begin
			done_o <= 1'b0;
			data_o <= ~last;
			if (start_a_i || start_b_i) begin
				busy <= 1'b1;
				cnt <= lat_i;
				code <= start_a_i ? code_a_i : code_b_i;
			end else if (busy && cnt == 8'h00) begin
				busy <= 1'b0;
				done_o <= 1'b1;
				data_o <= code;
				last <= code;
			end else if (busy) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// file: dv/tb_single_shunt_pwm_adc_sampler.sv
// Purpose: self-checking bench for the single-shunt pwm block
// Assumes: converter model on the far side
// Notes: duty patterns change just after each current update
`timescale 1ns/1ps
`default_nettype none
`include "shunt_pwm_defines.vh"
module tb_single_shunt_pwm_adc_sampler;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [12:0] du = 13'h0000, dv = 13'h0000, dw = 13'h0000;
	logic [11:0] ca = 12'h000, cb = 12'h000;
	logic duty_load_i = 1'b1;
	logic estop_i = 1'b0;
	logic [7:0] lat = 8'h02;
	wire done, sa, sb, oen, vld, ce, se, clamp;
	wire [11:0] data;
	wire [2:0] gu, gl;
	wire signed [15:0] iu, iv, iw;
	integer err_total = 0, n_tests = 0, seed = 32'ha679;
	logic [48:0] q[$];
	// six orderings, then close edges, then a pattern that must clamp
	logic [35:0] pat[8] = '{36'hFA09C43E8, 36'hFA03E89C4, 36'h9C4FA03E8, 36'h9C43E8FA0,
		36'h3E8FA09C4, 36'h3E89C4FA0, 36'hBB8B903E8, 36'h15E15414A};
	single_shunt_pwm_adc_sampler single_shunt_pwm_adc_sampler_i (.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i), .duty_u_i(du), .duty_v_i(dv), .duty_w_i(dw), .duty_load_i(duty_load_i),
		.dead_cnt_i(`DEAD_DEFAULT), .min_window_i(`WINDOW_DEFAULT), .estop_i(estop_i),
		.adc_done_i(done), .adc_data_i(data), .adc_start_a_o(sa), .adc_start_b_o(sb),
		.gate_upper_o(gu), .gate_lower_o(gl), .gate_oe_n_o(oen), .cur_u_o(iu), .cur_v_o(iv),
		.cur_w_o(iw), .cur_valid_o(vld), .ctrl_event_o(ce), .slow_event_o(se), .clamp_o(clamp));
	adc_model adc_model_i (.clk_i(ref_clk_i), .resetn_i(resetn_i), .start_a_i(sa), .start_b_i(sb),
		.code_a_i(ca), .code_b_i(cb), .lat_i(lat), .done_o(done), .data_o(data));
	// clock
	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	task automatic check(input string nm, input logic [48:0] exp, input logic [48:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic stop_test;
		$display("errors %0d checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// largest duty takes the A sample, smallest the negated B sample
	function automatic logic [48:0] expect_of(input logic [35:0] p, input logic [11:0] a, b, input logic cl);
		logic [15:0] c[3];
		logic [15:0] ia, ib;
		int hi, lo;
		hi = (p[35:24] > p[23:12] && p[35:24] > p[11:0]) ? 0 : (p[23:12] > p[11:0] ? 1 : 2);
		lo = (p[35:24] < p[23:12] && p[35:24] < p[11:0]) ? 0 : (p[23:12] < p[11:0] ? 1 : 2);
		ia = {4'h0, a} - {4'h0, `ADC_ZERO_CODE};
		ib = {4'h0, `ADC_ZERO_CODE} - {4'h0, b};
		c[hi] = ia;
		c[lo] = ib;
		c[3 - hi - lo] = -(ia + ib);
		return {cl, c[0], c[1], c[2]};
	endfunction
	// bounded wait for the next current update
	task automatic wait_vld;
		int n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (vld !== 1'b1 && n < 30000);
		if (vld !== 1'b1) begin
			err_total++;
			stop_test;
		end
	endtask
	// watcher: oldest note against each update
	always @(posedge ref_clk_i) begin
		if (vld === 1'b1 && q.size() > 0)
			check("currents", q.pop_front(), {clamp, iu, iv, iw});
	end
	initial begin
		repeat (10) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		// the first pattern goes in with reset release, zero duties never start a sample
		for (int i = 0; i < 8; i++) begin
			ca <= 12'($unsigned($random(seed)) % 32'hE8C);
			cb <= 12'($unsigned($random(seed)) % 32'hE8C);
			{du, dv, dw} <= {1'b0, pat[i][35:24], 1'b0, pat[i][23:12], 1'b0, pat[i][11:0]};
			lat <= (i < 6 && i[0]) ? 8'h78 : 8'h02;
			@(negedge ref_clk_i);
			q.push_back(expect_of(pat[i], ca, cb, i == 7));
			wait_vld;
		end
		@(negedge ref_clk_i);
		check("drive", 49'h0, {48'h0, oen});
		check("notes left", 49'h0, 49'(q.size()));
		@(posedge ref_clk_i);
		estop_i <= 1'b1;
		@(negedge ref_clk_i);
		check("float", 49'h1, {48'h0, oen});
		@(posedge ref_clk_i);
		estop_i <= 1'b0;
		@(negedge ref_clk_i);
		check("float held", 49'h1, {48'h0, oen});
		stop_test;
	end
endmodule
`default_nettype wire
